//--- src/pra_cmd_unit.v
// port read, accumulator op and compare command unit
`include "pra_defs.vh"
`default_nettype none
module pra_cmd_unit #(
    parameter [7:0] MODULE_ADDR = 8'h01,
    parameter [7:0] HOST_ADDR   = 8'h02
) (
    input  wire        core_clk,        // system clock, 100 MHz
    input  wire        rst,             // async reset, active high
    input  wire        standaloneMode,  // 1: stored program issues commands
    input  wire        rxValid,         // command byte valid
    input  wire [7:0]  rxByte,          // command byte
    output wire        rxReady,         // unit accepts a command byte
    output reg         txValid,         // reply byte valid
    output reg  [7:0]  txByte,          // reply byte
    input  wire        txReady,         // reply sink takes byte
    output reg         cmdDone,         // one-cycle pulse, standalone command finished
    input  wire [7:0]  generalInputs,   // async digital input pins
    input  wire [11:0] dualInputZero,   // converter result of first dual input
    input  wire [11:0] dualInputFour,   // converter result of second dual input
    input  wire [15:0] supplyTenths,    // supply voltage in tenths of a volt
    input  wire [15:0] tempZero,        // temperature, degrees Celsius
    input  wire [15:0] tempOne,         // temperature, degrees Celsius
    input  wire [15:0] tempTwo,         // temperature, degrees Celsius
    input  wire [7:0]  generalOutputs,  // output states set by port write command
    input  wire [2:0]  jumpCond,        // condition code of a conditional jump
    output reg  [31:0] accumulator,     // accumulator register
    output reg         condMet,         // selected jump condition holds
    output reg         zeroFlag,        // last compare: accumulator and operand both zero
    output reg         equalFlag,       // last compare: equal
    output reg         greaterFlag,     // last compare: signed greater
    output reg         lowerFlag        // last compare: signed lower
);
    localparam [2:0] ST_RX = 3'h0;
    localparam [2:0] ST_EXEC = 3'h1;
    localparam [2:0] ST_DIV = 3'h2;
    localparam [2:0] ST_TX = 3'h3;

    reg  [2:0]  state_reg;
    reg  [3:0]  idx_reg;
    reg  [7:0]  sum_reg;
    reg  [7:0]  addr_reg, instr_reg, type_reg, bank_reg;
    reg  [31:0] val_reg;
    reg  [7:0]  status_reg;
    reg  [31:0] reply_reg;
    reg  [7:0]  txSum_reg;
    reg  [7:0]  inMeta_reg, inSync_reg;

    // restoring divider: one quotient bit per cycle, keeps the timing short
    reg  [5:0]  divCnt_reg;
    reg  [31:0] divQ_reg, divR_reg, divD_reg;
    reg         divNegQ_reg, divNegR_reg;

    reg  [31:0] readVal;
    reg         readOk;
    wire [31:0] opnd = val_reg;
    wire [32:0] remTrial = {divR_reg, divQ_reg[31]} - {1'b0, divD_reg};
    wire [31:0] absAcc = accumulator[31] ? (~accumulator + 32'h1) : accumulator;
    wire [31:0] absOp = opnd[31] ? (~opnd + 32'h1) : opnd;

    assign rxReady = (state_reg == ST_RX);

    // two-flop synchroniser for the input pins
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inMeta_reg <= 8'h00;
            inSync_reg <= 8'h00;
        end else begin
            inMeta_reg <= generalInputs;
            inSync_reg <= inMeta_reg;
        end
    end

    // port selection
    always @* begin
        readVal = 32'h0;
        readOk = 1'b1;
        case (bank_reg)
            `PRA_BANK_DIN: begin
                if (type_reg == `PRA_PORT_ALL)
                    readVal = {24'h0, inSync_reg}; // RULE7
                else if (type_reg <= `PRA_PORT_LAST_DIG)
                    readVal = {31'h0, inSync_reg[type_reg[2:0]]}; // RULE2 RULE6
                else
                    readOk = 1'b0;
            end

            `PRA_BANK_ANA: begin
                case (type_reg) // RULE8
                    `PRA_PORT_ANA0: readVal = {20'h0, dualInputZero}; // RULE2 RULE6
                    `PRA_PORT_ANA4: readVal = {20'h0, dualInputFour};
                    `PRA_PORT_SUPPLY: readVal = {16'h0, supplyTenths};
                    `PRA_PORT_TEMP0: readVal = {16'h0, tempZero};
                    `PRA_PORT_TEMP1: readVal = {16'h0, tempOne};
                    `PRA_PORT_TEMP2: readVal = {16'h0, tempTwo};
                    default: readOk = 1'b0;
                endcase
            end

            `PRA_BANK_DOUT: begin
                if (type_reg <= `PRA_PORT_LAST_DIG)
                    readVal = {31'h0, generalOutputs[type_reg[2:0]]}; // RULE9
                else
                    readOk = 1'b0;
            end
            default: readOk = 1'b0;
        endcase
    end

    // jump condition evaluation from compare flags
    always @* begin
        case (jumpCond) // RULE15
            `PRA_CC_ZE: condMet = zeroFlag;
            `PRA_CC_NZ: condMet = ~zeroFlag;
            `PRA_CC_EQ: condMet = equalFlag;
            `PRA_CC_NE: condMet = ~equalFlag;

            `PRA_CC_GT: condMet = greaterFlag;
            `PRA_CC_GE: condMet = greaterFlag | equalFlag;
            `PRA_CC_LT: condMet = lowerFlag;
            `PRA_CC_LE: condMet = lowerFlag | equalFlag;
            default: condMet = 1'b0;
        endcase
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RX;
            idx_reg <= 4'h0;
            sum_reg <= 8'h00;
            addr_reg <= 8'h00;
            instr_reg <= 8'h00;
            type_reg <= 8'h00;
            bank_reg <= 8'h00;
            val_reg <= 32'h0;
            status_reg <= 8'h00;
            reply_reg <= 32'h0;
            txSum_reg <= 8'h00;
            txValid <= 1'b0;
            txByte <= 8'h00;
            cmdDone <= 1'b0;
            accumulator <= 32'h0;

            zeroFlag <= 1'b0;
            equalFlag <= 1'b0;
            greaterFlag <= 1'b0;
            lowerFlag <= 1'b0;

            divCnt_reg <= 6'h0;
            divQ_reg <= 32'h0;
            divR_reg <= 32'h0;
            divD_reg <= 32'h0;
            divNegQ_reg <= 1'b0;
            divNegR_reg <= 1'b0;
        end else begin
            cmdDone <= 1'b0;
            case (state_reg)
                ST_RX: begin
                    if (rxValid) begin // RULE16
                        case (idx_reg)
                            `PRA_IDX_ADDR: addr_reg <= rxByte;
                            `PRA_IDX_INSTR: instr_reg <= rxByte;
                            `PRA_IDX_TYPE: type_reg <= rxByte;
                            `PRA_IDX_BANK: bank_reg <= rxByte;
                            `PRA_IDX_VAL3: val_reg[31:24] <= rxByte;
                            `PRA_IDX_VAL2: val_reg[23:16] <= rxByte;
                            `PRA_IDX_VAL1: val_reg[15:8] <= rxByte;
                            `PRA_IDX_VAL0: val_reg[7:0] <= rxByte;
                            default: ;
                        endcase
                        if (idx_reg == `PRA_IDX_LAST) begin
                            idx_reg <= 4'h0;
                            sum_reg <= 8'h00;
                            // in direct mode, frames for another address are dropped silently; standalone accepts any address
                            if (standaloneMode || addr_reg == MODULE_ADDR) begin
                                status_reg <= (sum_reg == rxByte) ? `PRA_ST_OK
                                                                 : `PRA_ST_BAD_CHKSUM;
                                state_reg <= ST_EXEC;
                            end
                        end else begin
                            idx_reg <= idx_reg + 4'h1;
                            sum_reg <= sum_reg + rxByte;
                        end
                    end
                end

                ST_EXEC: begin
                    reply_reg <= 32'h0;
                    state_reg <= standaloneMode ? ST_RX : ST_TX;
                    cmdDone <= standaloneMode;
                    if (status_reg == `PRA_ST_OK) begin
                        case (instr_reg)
                            `PRA_INS_PORT_READ: begin // RULE1
                                if (!readOk)
                                    status_reg <= `PRA_ST_BAD_TYPE;
                                else if (standaloneMode)
                                    accumulator <= readVal; // RULE3
                                else
                                    reply_reg <= readVal; // RULE4 RULE5
                            end

                            `PRA_INS_ACC_OP: begin // RULE10 RULE11
                                reply_reg <= opnd; // RULE12
                                case (type_reg)
                                    `PRA_OP_ADD: accumulator <= accumulator + opnd;
                                    `PRA_OP_SUB: accumulator <= accumulator - opnd;
                                    `PRA_OP_MUL: accumulator <= accumulator * opnd;
                                    `PRA_OP_DIV, `PRA_OP_MOD: begin
                                        if (opnd == 32'h0) begin
                                            status_reg <= `PRA_ST_BAD_VALUE;
                                        end else begin
                                            // signed, truncating toward zero
                                            divQ_reg <= absAcc;
                                            divR_reg <= 32'h0;
                                            divD_reg <= absOp;
                                            divCnt_reg <= `PRA_DIV_STEPS;
                                            divNegQ_reg <= accumulator[31] ^ opnd[31];
                                            divNegR_reg <= accumulator[31];
                                            state_reg <= ST_DIV;
                                            cmdDone <= 1'b0;
                                        end
                                    end
                                    `PRA_OP_AND: accumulator <= accumulator & opnd;
                                    `PRA_OP_OR: accumulator <= accumulator | opnd;
                                    `PRA_OP_XOR: accumulator <= accumulator ^ opnd;
                                    `PRA_OP_NOT: accumulator <= ~accumulator;
                                    `PRA_OP_LOAD: accumulator <= opnd;
                                    default: status_reg <= `PRA_ST_BAD_TYPE;
                                endcase
                            end

                            `PRA_INS_COMPARE: begin // RULE13 RULE14
                                zeroFlag <= (accumulator == opnd) && (opnd == 32'h0);
                                equalFlag <= (accumulator == opnd);
                                greaterFlag <= ($signed(accumulator) > $signed(opnd));
                                lowerFlag <= ($signed(accumulator) < $signed(opnd));
                            end

                            default: status_reg <= `PRA_ST_BAD_CMD;
                        endcase
                    end
                end

                ST_DIV: begin
                    if (divCnt_reg != 6'h0) begin
                        divCnt_reg <= divCnt_reg - 6'h1;
                        if (!remTrial[32]) begin
                            divR_reg <= remTrial[31:0];
                            divQ_reg <= {divQ_reg[30:0], 1'b1};
                        end else begin
                            divR_reg <= {divR_reg[30:0], divQ_reg[31]};
                            divQ_reg <= {divQ_reg[30:0], 1'b0};
                        end
                    end else begin
                        if (type_reg == `PRA_OP_DIV)
                            accumulator <= divNegQ_reg ? (~divQ_reg + 32'h1) : divQ_reg;
                        else
                            accumulator <= divNegR_reg ? (~divR_reg + 32'h1) : divR_reg;
                        state_reg <= standaloneMode ? ST_RX : ST_TX;
                        cmdDone <= standaloneMode;
                    end
                end

                ST_TX: begin // RULE17
                    if (!txValid || txReady) begin
                        txValid <= 1'b1;
                        case (idx_reg)
                            `PRA_IDX_ADDR: txByte <= HOST_ADDR;
                            `PRA_IDX_INSTR: txByte <= MODULE_ADDR;
                            `PRA_IDX_TYPE: txByte <= status_reg;
                            `PRA_IDX_BANK: txByte <= instr_reg;
                            `PRA_IDX_VAL3: txByte <= reply_reg[31:24];
                            `PRA_IDX_VAL2: txByte <= reply_reg[23:16];
                            `PRA_IDX_VAL1: txByte <= reply_reg[15:8];
                            `PRA_IDX_VAL0: txByte <= reply_reg[7:0];
                            default: txByte <= txSum_reg;
                        endcase

                        case (idx_reg)
                            `PRA_IDX_ADDR: txSum_reg <= HOST_ADDR;
                            `PRA_IDX_INSTR: txSum_reg <= txSum_reg + MODULE_ADDR;
                            `PRA_IDX_TYPE: txSum_reg <= txSum_reg + status_reg;
                            `PRA_IDX_BANK: txSum_reg <= txSum_reg + instr_reg;
                            `PRA_IDX_VAL3: txSum_reg <= txSum_reg + reply_reg[31:24];
                            `PRA_IDX_VAL2: txSum_reg <= txSum_reg + reply_reg[23:16];
                            `PRA_IDX_VAL1: txSum_reg <= txSum_reg + reply_reg[15:8];
                            `PRA_IDX_VAL0: txSum_reg <= txSum_reg + reply_reg[7:0];
                            default: txSum_reg <= txSum_reg;
                        endcase

                        if (idx_reg == `PRA_FRAME_LEN) begin
                            txValid <= 1'b0;
                            idx_reg <= 4'h0;
                            state_reg <= ST_RX;
                        end else begin
                            idx_reg <= idx_reg + 4'h1;
                        end
                    end
                end

                default: state_reg <= ST_RX;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- src/pra_defs.vh
// constants of the port read and accumulator command unit
// Functional notes
// RULE1: port read is instruction 15; type is port, bank byte selects 0, 1 or 2.
// RULE2: digital reads give 0 or 1; converter reads give unsigned 0..4095.
// RULE3: standalone port read copies the read value into the accumulator.
// RULE4: direct port read replies with the value only; accumulator untouched.
// RULE5: direct port read replies status 100 with the port state.
// RULE6: bank 0 ports 0..7 are digital inputs; dual lines also read analog.
// RULE7: bank 0 port 255 packs all eight inputs into accumulator low bits.
// RULE8: bank 1: ports 0,4 analog, 8 supply tenths volt, 9..11 temperatures.
// RULE9: bank 2 ports 0..7 read back the eight digital output states.
// RULE10: accumulator op is instruction 19; result of type op stored in accumulator.
// RULE11: ops 0..9: add sub mul div mod and or xor invert load.
// RULE12: direct accumulator op replies status 100 echoing the operand.
// RULE13: compare is instruction 20; sets flags, accumulator unchanged.
// RULE14: issuer uses compare only in standalone programs.
// RULE15: flags support conditions 0..7 of conditional jump instruction 21.
// RULE16: command frame: addr, instr, type, bank, value msb first, sum checksum.
// RULE17: reply frame: host, target, status, instr, value msb first, sum checksum.
`ifndef PRA_DEFS_VH
`define PRA_DEFS_VH
`define PRA_INS_PORT_READ   8'h0F
`define PRA_INS_ACC_OP      8'h13
`define PRA_INS_COMPARE     8'h14
`define PRA_INS_COND_JUMP   8'h15
`define PRA_ST_OK           8'h64
`define PRA_ST_BAD_CHKSUM   8'h01
`define PRA_ST_BAD_CMD      8'h02
`define PRA_ST_BAD_TYPE     8'h03
`define PRA_ST_BAD_VALUE    8'h04
`define PRA_BANK_DIN        8'h00
`define PRA_BANK_ANA        8'h01
`define PRA_BANK_DOUT       8'h02
`define PRA_PORT_ALL        8'hFF
`define PRA_PORT_ANA0       8'h00
`define PRA_PORT_ANA4       8'h04
`define PRA_PORT_SUPPLY     8'h08
`define PRA_PORT_TEMP0      8'h09
`define PRA_PORT_TEMP1      8'h0A
`define PRA_PORT_TEMP2      8'h0B
`define PRA_PORT_LAST_DIG   8'h07
`define PRA_OP_ADD          8'h00
`define PRA_OP_SUB          8'h01
`define PRA_OP_MUL          8'h02
`define PRA_OP_DIV          8'h03
`define PRA_OP_MOD          8'h04
`define PRA_OP_AND          8'h05
`define PRA_OP_OR           8'h06
`define PRA_OP_XOR          8'h07
`define PRA_OP_NOT          8'h08
`define PRA_OP_LOAD         8'h09
`define PRA_CC_ZE           3'h0
`define PRA_CC_NZ           3'h1
`define PRA_CC_EQ           3'h2
`define PRA_CC_NE           3'h3
`define PRA_CC_GT           3'h4
`define PRA_CC_GE           3'h5
`define PRA_CC_LT           3'h6
`define PRA_CC_LE           3'h7
`define PRA_FRAME_LEN       4'h9
`define PRA_IDX_LAST        4'h8
`define PRA_IDX_ADDR        4'h0
`define PRA_IDX_INSTR       4'h1
`define PRA_IDX_TYPE        4'h2
`define PRA_IDX_BANK        4'h3
`define PRA_IDX_VAL3        4'h4
`define PRA_IDX_VAL2        4'h5
`define PRA_IDX_VAL1        4'h6
`define PRA_IDX_VAL0        4'h7
`define PRA_ADC_W           12
`define PRA_DIV_STEPS       6'h20
`endif

//--- dv/pra_reply_sink.sv
// reply sink model that stalls txReady
`default_nettype none
module pra_reply_sink (
    input  wire logic core_clk, // clock
    input  wire logic rst,      // async reset
    output var  logic txReady   // takes reply byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phaseReg;
    // stalls one cycle in three
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phaseReg <= 2'h0;
            txReady  <= 1'b0;
        end else begin
            phaseReg <= (phaseReg == 2'h2) ? 2'h0 : phaseReg + 2'h1;
            txReady  <= phaseReg != 2'h2;
        end
    end
endmodule
`default_nettype wire

//--- dv/pra_cmd_unit_properties.sv
// assertions on the unit's ports
`default_nettype none
module pra_cmd_unit_checker #(
    parameter [7:0] HOST_ADDR = 8'h02
) (
    input wire logic        core_clk,       // clock
    input wire logic        rst,            // reset
    input wire logic        standaloneMode, // program mode
    input wire logic        rxReady,        // byte taken
    input wire logic        txValid,        // reply valid
    input wire logic [7:0]  txByte,         // reply byte
    input wire logic        txReady,        // sink ready
    input wire logic        cmdDone,        // done pulse
    input wire logic [2:0]  jumpCond,       // condition
    input wire logic [31:0] accumulator,    // accumulator
    input wire logic        condMet,        // condition holds
    input wire logic        zeroFlag,       // zero
    input wire logic        equalFlag,      // equal
    input wire logic        greaterFlag,    // greater
    input wire logic        lowerFlag       // lower
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    reply_opens_host_a: assert property ($rose(txValid) |-> txByte == HOST_ADDR)
        else $error("reply does not start with host address");
    reply_byte_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
        else $error("reply byte not held");
    rx_closed_reply_a: assert property (txValid |-> !rxReady)
        else $error("rx open during reply");
    reply_direct_only_a: assert property (txValid |-> !standaloneMode)
        else $error("reply in standalone");
    done_single_pulse_a: assert property (cmdDone |-> standaloneMode ##1 !cmdDone)
        else $error("done pulse wrong");
    acc_then_done_a: assert property (standaloneMode && !$stable(accumulator) |-> cmdDone)
        else $error("acc change without done");
    flags_exclusive_a: assert property (!(greaterFlag && lowerFlag)
        && !(equalFlag && (greaterFlag || lowerFlag))) else $error("compare flags conflict");
    zero_means_equal_a: assert property (zeroFlag |-> equalFlag)
        else $error("zero without equal");
    flags_then_done_a: assert property (
        !$stable({zeroFlag, equalFlag, greaterFlag, lowerFlag}) |-> cmdDone)
        else $error("flags change without done");
    cond_zero_eq_a: assert property (!jumpCond[2] |-> condMet ==
        ((jumpCond[1] ? equalFlag : zeroFlag) ^ jumpCond[0])) else $error("zero or equal cond");
    cond_order_a: assert property (jumpCond[2] |-> condMet ==
        ((jumpCond[1] ? lowerFlag : greaterFlag) || (jumpCond[0] && equalFlag)))
        else $error("ordering condition wrong");
endmodule
bind pra_cmd_unit pra_cmd_unit_checker #(.HOST_ADDR(HOST_ADDR)) chk (
    .core_clk(core_clk), .rst(rst), .standaloneMode(standaloneMode), .rxReady(rxReady),
    .txValid(txValid), .txByte(txByte), .txReady(txReady), .cmdDone(cmdDone),
    .jumpCond(jumpCond), .accumulator(accumulator), .condMet(condMet), .zeroFlag(zeroFlag),
    .equalFlag(equalFlag), .greaterFlag(greaterFlag), .lowerFlag(lowerFlag)
);
`default_nettype wire

//--- dv/pra_cmd_unit_tb.sv
// self-checking bench of the command unit
`default_nettype none
module pra_cmd_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [95:0] DPORTS = 96'h000407_000408090A0B_000507;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        standaloneMode = 1'b0;
    logic        rxValid = 1'b0;
    logic [7:0]  rxByte;
    logic [7:0]  generalInputs;
    logic [11:0] dualInputZero;
    logic [11:0] dualInputFour;
    logic [15:0] supplyTenths;
    logic [15:0] tempZero = 16'h0000;
    logic [15:0] tempOne;
    logic [15:0] tempTwo;
    logic [7:0]  generalOutputs;
    logic [2:0]  jumpCond = 3'h0;
    wire logic   rxReady, txValid, txReady, cmdDone, condMet;
    wire logic   zeroFlag, equalFlag, greaterFlag, lowerFlag;
    wire logic [7:0]  txByte;
    wire logic [31:0] accumulator;
    logic [7:0]  byteQ[$];
    logic [31:0] accQ[$];
    logic [31:0] accModel = 32'h0;
    logic [31:0] v, a, b;
    logic [7:0]  pt;
    integer      error_cnt = 0, check_count = 0, seed = 73, cycles = 0, i, j;
    pra_cmd_unit uut (.core_clk(core_clk), .rst(rst), .standaloneMode(standaloneMode),
        .rxValid(rxValid), .rxByte(rxByte), .rxReady(rxReady), .txValid(txValid),
        .txByte(txByte), .txReady(txReady), .cmdDone(cmdDone), .generalInputs(generalInputs),
        .dualInputZero(dualInputZero), .dualInputFour(dualInputFour),
        .supplyTenths(supplyTenths), .tempZero(tempZero), .tempOne(tempOne), .tempTwo(tempTwo),
        .generalOutputs(generalOutputs), .jumpCond(jumpCond), .accumulator(accumulator),
        .condMet(condMet), .zeroFlag(zeroFlag), .equalFlag(equalFlag),
        .greaterFlag(greaterFlag), .lowerFlag(lowerFlag));
    pra_reply_sink sink (.core_clk(core_clk), .rst(rst), .txReady(txReady));
    initial forever #5 core_clk = ~core_clk;
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // bad skews the checksum
    task send(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bank,
              input logic [31:0] val, input logic [7:0] bad = 8'h00);
        logic [71:0] f;
        f = {8'h01, ins, typ, bank, val, bad};
        for (int k = 0; k < 8; k++) f[7:0] = f[7:0] + f[71-8*k -: 8];
        @(posedge core_clk);
        rxValid <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            rxByte <= f[71-8*k -: 8];
            do @(negedge core_clk); while (rxReady !== 1'b1);
            @(posedge core_clk);
        end
        rxValid <= 1'b0;
    endtask
    task expect_reply(input logic [7:0] st, input logic [7:0] ins, input logic [31:0] val);
        logic [71:0] r;
        r = {8'h02, 8'h01, st, ins, val, 8'h00};
        for (int k = 0; k < 8; k++) r[7:0] = r[7:0] + r[71-8*k -: 8];
        for (int k = 0; k < 9; k++) byteQ.push_back(r[71-8*k -: 8]);
    endtask
    task drain;
        while (byteQ.size() + accQ.size() != 0) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
    endtask
    function logic [31:0] port_val(input logic [7:0] bank, input logic [7:0] port);
        port_val = {31'h0, generalOutputs[port[2:0]]};
        if (bank == 8'h00)
            port_val = port == 8'hFF ? {24'h0, generalInputs}
                : {31'h0, generalInputs[port[2:0]]};
        if (bank == 8'h01) case (port)
            8'h00: port_val = {20'h0, dualInputZero};
            8'h04: port_val = {20'h0, dualInputFour};
            8'h08: port_val = {16'h0, supplyTenths};
            8'h09: port_val = {16'h0, tempZero};
            8'h0A: port_val = {16'h0, tempOne};
            default: port_val = {16'h0, tempTwo};
        endcase
    endfunction
    function logic [31:0] accumulator_op_cmd(input logic [7:0] op, input logic [31:0] x, input logic [31:0] y);
        case (op)
            8'h00: accumulator_op_cmd = x + y;
            8'h01: accumulator_op_cmd = x - y;
            8'h02: accumulator_op_cmd = x * y;
            8'h03: accumulator_op_cmd = $signed(x) / $signed(y);
            8'h04: accumulator_op_cmd = $signed(x) % $signed(y);
            8'h05: accumulator_op_cmd = x & y;
            8'h06: accumulator_op_cmd = x | y;
            8'h07: accumulator_op_cmd = x ^ y;
            8'h08: accumulator_op_cmd = ~x;
            default: accumulator_op_cmd = y;
        endcase
    endfunction
    function logic cond_exp(input logic [2:0] cc, input logic [31:0] x, input logic [31:0] y);
        logic gt, eq;
        gt = $signed(x) > $signed(y);
        eq = x == y;
        case (cc[2:1])
            2'h0: cond_exp = (x == 32'h0 && y == 32'h0) ^ cc[0];
            2'h1: cond_exp = eq ^ cc[0];
            2'h2: cond_exp = gt | (eq & cc[0]);
            default: cond_exp = (!gt && !eq) | (eq & cc[0]);
        endcase
    endfunction
    always @(posedge core_clk) begin
        cycles++;
        if (txValid === 1'b1 && txReady === 1'b1)
            cmp8(txByte, byteQ.size() > 0 ? byteQ.pop_front() : 8'hXX);
        if (cmdDone === 1'b1)
            cmp32(accumulator, accQ.size() > 0 ? accQ.pop_front() : 32'hXXXXXXXX);
        if (cycles > 6000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        {generalInputs, dualInputZero, dualInputFour} <= $random(seed);
        {supplyTenths, generalOutputs, tempZero[7:0]} <= $random(seed);
        {tempOne, tempTwo} <= $random(seed) & 32'h00FF00FF;
        // let inputs cross the synchroniser
        repeat (4) @(posedge core_clk);
        for (i = 0; i < 12; i++) begin
            pt = DPORTS[95-8*i -: 8];
            a = i < 3 ? 32'h0 : i < 9 ? 32'h1 : 32'h2;
            expect_reply(8'h64, 8'h0F, port_val(a[7:0], pt));
            send(8'h0F, pt, a[7:0], $random(seed));
            drain;
            cmp32(accumulator, accModel);
        end
        expect_reply(8'h01, 8'h13, 32'h0);
        send(8'h13, 8'h09, 8'h00, 32'h5555AAAA, 8'h01);
        drain;
        v = $random(seed);
        expect_reply(8'h64, 8'h13, v);
        send(8'h13, 8'h09, 8'h00, v);
        drain;
        accModel = v;
        cmp32(accumulator, accModel);
        standaloneMode <= 1'b1;
        for (i = 0; i < 10; i++) begin
            v = $random(seed) | 32'h1;
            accModel = accumulator_op_cmd(i[7:0], accModel, v);
            accQ.push_back(accModel);
            send(8'h13, i[7:0], 8'h00, v);
            drain;
        end
        for (i = 0; i < 3; i++) begin
            pt = i == 0 ? 8'hFF : i == 1 ? 8'h04 : 8'h06;
            accModel = port_val(i[7:0], pt);
            accQ.push_back(accModel);
            send(8'h0F, pt, i[7:0], 32'h0);
            drain;
        end
        for (i = 0; i < 8; i++) begin
            a = i == 0 ? 32'h0 : $random(seed) % 3;
            b = i == 0 ? 32'h0 : $random(seed) % 3;
            accQ.push_back(a);
            send(8'h13, 8'h09, 8'h00, a);
            drain;
            accQ.push_back(a);
            send(8'h14, 8'h00, 8'h00, b);
            drain;
            for (j = 0; j < 8; j++) begin
                @(posedge core_clk);
                jumpCond <= j[2:0];
                @(negedge core_clk);
                cmp8({7'h0, condMet}, {7'h0, cond_exp(j[2:0], a, b)});
            end
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
